// ==== verilog/alarm_pkg.sv ====
// constants, register layout and carriers for the dual alarm monitor
package alarm_pkg;
   localparam int DATA_W = 14;
   localparam int COUNT_W = 8;
   localparam int SRC_W = 3;
   localparam int FRAME_BITS = 16;
   localparam int ADDR_W = 7;
   localparam logic [3:0] LAST_BIT = 4'hF;
   localparam logic [ADDR_W-1:0] ADDR_ALARM1_THRESHOLD = 7'h20;
   localparam logic [ADDR_W-1:0] ADDR_ALARM2_THRESHOLD = 7'h22;
   localparam logic [ADDR_W-1:0] ADDR_ALARM1_COUNT = 7'h24;
   localparam logic [ADDR_W-1:0] ADDR_ALARM2_COUNT = 7'h26;
   localparam logic [ADDR_W-1:0] ADDR_ALARM_CONTROL = 7'h28;
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [15:0] THRESHOLD_MASK = 16'hBFFF;
   localparam logic [15:0] COUNT_MASK = 16'h00FF;
   localparam logic [15:0] CONTROL_MASK = 16'hFF37;
   localparam int WRITE_FLAG_BIT = 15;
   localparam int LIMIT_ABOVE_BIT = 15;
   localparam int CTL_SLOPE2 = 15;
   localparam int CTL_SRC2_LSB = 12;
   localparam int CTL_SLOPE1 = 11;
   localparam int CTL_SRC1_LSB = 8;
   localparam int CTL_FILT2 = 5;
   localparam int CTL_FILT1 = 4;
   localparam int CTL_OUT_EN = 2;
   localparam int CTL_OUT_POL = 1;
   localparam int CTL_OUT_LINE = 0;
   localparam logic [SRC_W-1:0] SRC_OFF = 3'h0;
   localparam logic [SRC_W-1:0] SRC_SUPPLY = 3'h1;
   localparam logic [SRC_W-1:0] SRC_UNUSED_A = 3'h2;
   localparam logic [SRC_W-1:0] SRC_UNUSED_B = 3'h3;
   localparam logic [SRC_W-1:0] SRC_AUX = 3'h4;
   localparam logic [SRC_W-1:0] SRC_TEMP = 3'h5;
   localparam logic [SRC_W-1:0] SRC_FULL = 3'h6;
   localparam logic [SRC_W-1:0] SRC_HALF = 3'h7;

   typedef enum logic [1:0] {
      SPI_IDLE = 2'b01,
      SPI_SHIFT = 2'b10
   } spi_state_e;

   typedef struct packed {
      logic [15:0] alarm1_threshold;
      logic [15:0] alarm2_threshold;
      logic [15:0] alarm1_slope_sample_count;
      logic [15:0] alarm2_slope_sample_count;
      logic [15:0] alarm_control;
   } alarm_regs_s;

   typedef struct packed {
      logic [DATA_W-1:0] supply;
      logic [DATA_W-1:0] aux;
      logic [DATA_W-1:0] temp;
      logic [DATA_W-1:0] full_circle_tilt_output;
      logic [DATA_W-1:0] half_circle_tilt_output;
   } sample_set_s;
endpackage

// ==== verilog/alarm_eval.sv ====
// one alarm channel: threshold or averaged rate-of-change comparison
`timescale 1ns/1ns
module alarm_eval import alarm_pkg::*; #(
   parameter int DW = DATA_W,
   parameter int CW = COUNT_W
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic sample_tick,
   input wire logic enable,
   input wire logic rate_of_change_mode,
   input wire logic above,
   input wire logic signed_fmt,
   input wire logic [DW-1:0] threshold,
   input wire logic [CW-1:0] count,
   input wire logic [DW-1:0] sample,
   output logic alarm_active
);
   if (DW < 2 || CW < 1) begin : g_bad_width
      $error("alarm_eval: widths too small");
   end

   localparam int EW = DW + 2;
   localparam int PW = EW + CW + 1;

   logic primed;
   logic [CW-1:0] win_cnt;
   logic signed [EW-1:0] start_val;

   // source format decides sign extension of both sample and threshold
   wire logic signed [EW-1:0] sample_ext = signed_fmt ? EW'($signed(sample)) : EW'(sample);
   wire logic signed [EW-1:0] limit_ext = signed_fmt ? EW'($signed(threshold)) : EW'(threshold);
   // a slope can fall as well as rise, so the slope limit is always signed
   wire logic signed [EW-1:0] slope_ext = EW'($signed(threshold));
   wire logic [CW-1:0] n_eff = (count == '0) ? CW'(1) : count;
   wire logic last_of_window = (CW'(win_cnt + CW'(1)) == n_eff);
   wire logic signed [EW-1:0] delta = sample_ext - start_val;
   // delta/n compared with limit becomes delta against limit*n: no divider
   wire logic signed [PW-1:0] delta_w = PW'(delta);
   wire logic signed [PW-1:0] limit_w = PW'(slope_ext) * $signed({1'b0, n_eff});
   wire logic level_hit = above ? (sample_ext > limit_ext) : (sample_ext < limit_ext);
   wire logic slope_hit = above ? (delta_w > limit_w) : (delta_w < limit_w);

   always_ff @(posedge sys_clk) begin
      if (!reset_n || !enable) begin
         alarm_active <= 1'b0;
         primed <= 1'b0;
         win_cnt <= '0;
         start_val <= '0;
      end else if (sample_tick) begin
         if (!rate_of_change_mode) begin
            alarm_active <= level_hit;
            primed <= 1'b0;
         end else if (!primed) begin
            start_val <= sample_ext;
            primed <= 1'b1;
            win_cnt <= '0;
         end else if (last_of_window) begin
            alarm_active <= slope_hit;
            start_val <= sample_ext;
            win_cnt <= '0;
         end else begin
            win_cnt <= CW'(win_cnt + CW'(1));
         end
      end
   end

   disabled_quiet_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !enable |=> !alarm_active) else $error("disabled alarm is active");
   level_compare_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      enable && sample_tick && !rate_of_change_mode |=> alarm_active == $past(level_hit))
      else $error("threshold compare result wrong");
   hold_between_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      enable && !sample_tick |=> alarm_active == $past(alarm_active))
      else $error("alarm changed between samples");
   window_bound_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      enable && rate_of_change_mode && primed |-> win_cnt < n_eff)
      else $error("slope window overran its count");
endmodule // alarm_eval

// ==== verilog/alarm_monitor.sv ====
// dual alarm monitor: serial register port, two alarm channels, alarm pin steering
//
// Operation
// - alarm 1 sample count is the low byte; upper byte unused
// - alarm 2 sample count is the low byte; upper byte unused
// - slope mode averages change over the count, compares with the threshold
// - threshold and count registers survive power cycles through the storage image
// - all alarm registers read zero after reset until written or restored from the storage image
// - alarm 2 threshold bit 15 picks above or below detection
// - alarm 2 threshold value in bits 13..0, bit 14 unused, source format
// - control bit 15 selects slope mode for alarm 2
// - control bits 14..12 pick alarm 2 source; zero disables
// - control bit 11 selects slope mode for alarm 1
// - control bits 10..8 pick alarm 1 source; zero disables
// - source codes: supply, aux, temperature, full-circle and half-circle tilt
// - control bits 5 and 4 select filtered data for alarms 2 and 1
// - control bit 2 enables alarm pin, bit 1 sets its polarity
// - control bit 0 routes the alarm pin to line b, else line a
// - one pin flags either alarm; status shows which one fired
// - misc control beats alarm control, which beats general io control
// - alarm 1 threshold bit 15 picks above or below, value low 14 bits
`timescale 1ns/1ns
module alarm_monitor import alarm_pkg::*; (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   input wire logic sample_tick,
   input wire sample_set_s sample_raw,
   input wire sample_set_s sample_filtered,
   input wire logic nv_valid,
   input wire alarm_regs_s nv_image,
   output alarm_regs_s nv_store,
   input wire logic [1:0] misc_claim,
   input wire logic [1:0] misc_level,
   input wire logic [1:0] gpio_drive,
   input wire logic [1:0] gpio_level,
   output logic [1:0] dio_out,
   output logic [1:0] dio_oe_n,
   output logic [1:0] alarm_active
);
   alarm_regs_s regs;
   logic load_pending;
   spi_state_e spi_state;
   logic sclk_meta, sclk_sync, sclk_prev;
   logic cs_meta, cs_sync, cs_prev;
   logic mosi_meta, mosi_sync;
   logic [3:0] bit_cnt;
   logic [FRAME_BITS-1:0] shift_in;
   logic [FRAME_BITS-1:0] shift_out;
   logic [ADDR_W-1:0] read_ptr;

   // pin side: two flops before anything looks at the serial lines
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         sclk_meta <= 1'b1;
         sclk_sync <= 1'b1;
         sclk_prev <= 1'b1;
         cs_meta <= 1'b1;
         cs_sync <= 1'b1;
         cs_prev <= 1'b1;
         mosi_meta <= 1'b0;
         mosi_sync <= 1'b0;
      end else begin
         sclk_meta <= spi_sclk;
         sclk_sync <= sclk_meta;
         sclk_prev <= sclk_sync;
         cs_meta <= spi_cs_n;
         cs_sync <= cs_meta;
         cs_prev <= cs_sync;
         mosi_meta <= spi_mosi;
         mosi_sync <= mosi_meta;
      end
   end

   wire logic frame_start = cs_prev && !cs_sync;
   wire logic sclk_rise = !sclk_prev && sclk_sync && !cs_sync;
   wire logic sclk_fall = sclk_prev && !sclk_sync && !cs_sync;
   wire logic in_frame = (spi_state == SPI_SHIFT);
   wire logic frame_done = in_frame && sclk_rise && (bit_cnt == LAST_BIT);
   wire logic [FRAME_BITS-1:0] next_shift_in = {shift_in[FRAME_BITS-2:0], mosi_sync};
   wire logic wr_strobe = frame_done && next_shift_in[WRITE_FLAG_BIT];
   wire logic rd_request = frame_done && !next_shift_in[WRITE_FLAG_BIT];
   wire logic [ADDR_W-1:0] frame_addr = next_shift_in[FRAME_BITS-2:8];
   wire logic [7:0] frame_data = next_shift_in[7:0];
   wire logic [ADDR_W-2:0] frame_word = frame_addr[ADDR_W-1:1];
   wire logic frame_high = frame_addr[0];

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         spi_state <= SPI_IDLE;
         bit_cnt <= '0;
         shift_in <= '0;
      end else begin
         unique case (spi_state)
            SPI_IDLE: begin
               if (frame_start) begin
                  spi_state <= SPI_SHIFT;
               end
               bit_cnt <= '0;
            end
            SPI_SHIFT: begin
               if (cs_sync) begin
                  spi_state <= SPI_IDLE;
               end else if (sclk_rise) begin
                  shift_in <= next_shift_in;
                  bit_cnt <= 4'(bit_cnt + 4'h1);
               end
            end
         endcase
      end
   end

   // read word decode: unmapped addresses read zero
   wire logic [15:0] read_word =
      (read_ptr[ADDR_W-1:1] == ADDR_ALARM1_THRESHOLD[ADDR_W-1:1]) ? regs.alarm1_threshold :
      (read_ptr[ADDR_W-1:1] == ADDR_ALARM2_THRESHOLD[ADDR_W-1:1]) ? regs.alarm2_threshold :
      (read_ptr[ADDR_W-1:1] == ADDR_ALARM1_COUNT[ADDR_W-1:1]) ? regs.alarm1_slope_sample_count :
      (read_ptr[ADDR_W-1:1] == ADDR_ALARM2_COUNT[ADDR_W-1:1]) ? regs.alarm2_slope_sample_count :
      (read_ptr[ADDR_W-1:1] == ADDR_ALARM_CONTROL[ADDR_W-1:1]) ? regs.alarm_control : REG_RESET;

   // a read frame names the word; its data goes out on the following frame
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         read_ptr <= '0;
         shift_out <= '0;
      end else begin
         if (rd_request) begin
            read_ptr <= frame_addr;
         end
         if (frame_start) begin
            shift_out <= read_word;
         end else if (in_frame && sclk_fall && bit_cnt != '0) begin
            // the first fall comes before any rise: the msb must still stand for it
            shift_out <= {shift_out[FRAME_BITS-2:0], 1'b0};
         end
      end
   end
   assign spi_miso = shift_out[FRAME_BITS-1];

   function automatic logic [15:0] merge_byte(input logic [15:0] cur, input logic hi,
                                              input logic [7:0] data, input logic [15:0] mask);
      logic [15:0] merged;
      merged = hi ? {data, cur[7:0]} : {cur[15:8], data};
      return merged & mask;
   endfunction

   wire logic hit_lim1 = wr_strobe && (frame_word == ADDR_ALARM1_THRESHOLD[ADDR_W-1:1]);
   wire logic hit_lim2 = wr_strobe && (frame_word == ADDR_ALARM2_THRESHOLD[ADDR_W-1:1]);
   wire logic hit_cnt1 = wr_strobe && (frame_word == ADDR_ALARM1_COUNT[ADDR_W-1:1]);
   wire logic hit_cnt2 = wr_strobe && (frame_word == ADDR_ALARM2_COUNT[ADDR_W-1:1]);
   wire logic hit_ctl = wr_strobe && (frame_word == ADDR_ALARM_CONTROL[ADDR_W-1:1]);

   // writes are byte wide; masks keep unused bits at zero
   wire logic [15:0] next_lim1 = merge_byte(regs.alarm1_threshold, frame_high, frame_data,
                                            THRESHOLD_MASK);
   wire logic [15:0] next_lim2 = merge_byte(regs.alarm2_threshold, frame_high, frame_data,
                                            THRESHOLD_MASK);
   wire logic [15:0] next_cnt1 = merge_byte(regs.alarm1_slope_sample_count, frame_high, frame_data,
                                            COUNT_MASK);
   wire logic [15:0] next_cnt2 = merge_byte(regs.alarm2_slope_sample_count, frame_high, frame_data,
                                            COUNT_MASK);
   wire logic [15:0] next_ctl = merge_byte(regs.alarm_control, frame_high, frame_data,
                                           CONTROL_MASK);

   // storage image is restored once after reset; it is a strap, so taken on a clock edge
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         regs <= {5{REG_RESET}};
         load_pending <= 1'b1;
      end else begin
         load_pending <= 1'b0;
         if (load_pending && nv_valid) begin
            regs.alarm1_threshold <= nv_image.alarm1_threshold & THRESHOLD_MASK;
            regs.alarm2_threshold <= nv_image.alarm2_threshold & THRESHOLD_MASK;
            regs.alarm1_slope_sample_count <= nv_image.alarm1_slope_sample_count & COUNT_MASK;
            regs.alarm2_slope_sample_count <= nv_image.alarm2_slope_sample_count & COUNT_MASK;
            regs.alarm_control <= nv_image.alarm_control & CONTROL_MASK;
         end else begin
            if (hit_lim1) regs.alarm1_threshold <= next_lim1;
            if (hit_lim2) regs.alarm2_threshold <= next_lim2;
            if (hit_cnt1) regs.alarm1_slope_sample_count <= next_cnt1;
            if (hit_cnt2) regs.alarm2_slope_sample_count <= next_cnt2;
            if (hit_ctl) regs.alarm_control <= next_ctl;
         end
      end
   end
   assign nv_store = regs;

   // per-channel source selection and evaluation
   wire logic [1:0][15:0] limit_reg = {regs.alarm2_threshold, regs.alarm1_threshold};
   wire logic [1:0][15:0] cnt_reg = {regs.alarm2_slope_sample_count, regs.alarm1_slope_sample_count};
   wire logic [1:0][SRC_W-1:0] src_sel = {regs.alarm_control[CTL_SRC2_LSB +: SRC_W],
                                          regs.alarm_control[CTL_SRC1_LSB +: SRC_W]};
   wire logic [1:0] slope_sel = {regs.alarm_control[CTL_SLOPE2], regs.alarm_control[CTL_SLOPE1]};
   wire logic [1:0] filt_sel = {regs.alarm_control[CTL_FILT2], regs.alarm_control[CTL_FILT1]};

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_alarm
         wire sample_set_s pick_set = filt_sel[ch] ? sample_filtered : sample_raw;
         wire logic [DATA_W-1:0] pick_val =
            (src_sel[ch] == SRC_SUPPLY) ? pick_set.supply :
            (src_sel[ch] == SRC_AUX) ? pick_set.aux :
            (src_sel[ch] == SRC_TEMP) ? pick_set.temp :
            (src_sel[ch] == SRC_FULL) ? pick_set.full_circle_tilt_output :
            pick_set.half_circle_tilt_output;
         // off and the two unused codes all leave the channel disabled
         wire logic ch_enable = (src_sel[ch] != SRC_OFF) && (src_sel[ch] != SRC_UNUSED_A) &&
                                (src_sel[ch] != SRC_UNUSED_B);
         alarm_eval #(.DW(DATA_W), .CW(COUNT_W)) u_eval (
            .sys_clk(sys_clk),
            .reset_n(reset_n),
            .sample_tick(sample_tick),
            .enable(ch_enable),
            .rate_of_change_mode(slope_sel[ch]),
            .above(limit_reg[ch][LIMIT_ABOVE_BIT]),
            .signed_fmt(src_sel[ch] == SRC_HALF),
            .threshold(limit_reg[ch][DATA_W-1:0]),
            .count(cnt_reg[ch][COUNT_W-1:0]),
            .sample(pick_val),
            .alarm_active(alarm_active[ch])
         );
      end
   endgenerate

   // one pin for both alarms; alarm_active tells the host which one fired
   wire logic alarm_any = |alarm_active;
   wire logic pin_enable = regs.alarm_control[CTL_OUT_EN];
   wire logic pin_level = regs.alarm_control[CTL_OUT_POL] ? alarm_any : !alarm_any;
   wire logic [1:0] alarm_claim = {pin_enable && regs.alarm_control[CTL_OUT_LINE],
                                   pin_enable && !regs.alarm_control[CTL_OUT_LINE]};

   genvar ln;
   generate
      for (ln = 0; ln < 2; ln++) begin : g_line
         wire logic next_level = misc_claim[ln] ? misc_level[ln] :
                                 alarm_claim[ln] ? pin_level : gpio_level[ln];
         wire logic next_drive = misc_claim[ln] || alarm_claim[ln] || gpio_drive[ln];
         always_ff @(posedge sys_clk) begin
            if (!reset_n) begin
               dio_out[ln] <= 1'b0;
               dio_oe_n[ln] <= 1'b1;
            end else begin
               dio_out[ln] <= next_level;
               dio_oe_n[ln] <= !next_drive;
            end
         end
      end
   endgenerate

   misc_priority_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      misc_claim[0] |=> dio_out[0] == $past(misc_level[0]) && !dio_oe_n[0])
      else $error("misc control lost line a");
   alarm_pin_level_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !misc_claim[1] && pin_enable && regs.alarm_control[CTL_OUT_LINE]
      |=> !dio_oe_n[1] && dio_out[1] == ($past(regs.alarm_control[CTL_OUT_POL]) ~^ $past(alarm_any)))
      else $error("alarm pin level or polarity wrong");
   unused_zero_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (regs.alarm_control & ~CONTROL_MASK) == '0 && regs.alarm1_slope_sample_count[15:8] == '0
      && regs.alarm2_threshold[14] == 1'b0) else $error("unused register bit set");
   write_lands_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      hit_ctl && !load_pending |=> regs.alarm_control == $past(next_ctl))
      else $error("control write did not land");
endmodule // alarm_monitor

// ==== sim/spi_host.sv ====
// serial host model: issues 16-bit register frames, clock idles high
`timescale 1ns/1ns
module spi_host (
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_mosi,
   input wire logic spi_miso
);
   localparam int HALF_NS = 40;
   initial begin
      spi_sclk = 1'b1;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
   end
   // msb first, data set on the fall and read back on the rise
   task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
      spi_cs_n = 1'b0;
      #HALF_NS;
      for (int i = 15; i >= 0; i--) begin
         spi_sclk = 1'b0;
         spi_mosi = tx[i];
         #HALF_NS;
         spi_sclk = 1'b1;
         rx[i] = spi_miso;
         #HALF_NS;
      end
      spi_cs_n = 1'b1;
      // flip the idle data so stale bits never look like a fresh frame
      spi_mosi = ~spi_mosi;
      #(3 * HALF_NS);
   endtask
endmodule // spi_host

// ==== sim/alarm_monitor_test.sv ====
// self-checking bench for the dual alarm monitor
`timescale 1ns/1ns
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
   $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module alarm_monitor_test import alarm_pkg::*; ();
   logic sys_clk, reset_n, sample_tick, nv_valid, e1, e2, den, eo;
   logic spi_sclk, spi_cs_n, spi_mosi, spi_miso;
   sample_set_s sample_raw, sample_filtered;
   alarm_regs_s nv_image, nv_store;
   logic [1:0] misc_claim, misc_level, gpio_drive, gpio_level, dio_out, dio_oe_n, alarm_active;
   logic [2:0] s1, s2;
   logic [15:0] rd, ctl, t1, t2;
   logic [95:0] rnd;
   int err_total, cmp_count, cyc;

   spi_host host (.spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso);
   alarm_monitor dut (.sys_clk, .reset_n, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso, .sample_tick,
      .sample_raw, .sample_filtered, .nv_valid, .nv_image, .nv_store, .misc_claim, .misc_level,
      .gpio_drive, .gpio_level, .dio_out, .dio_oe_n, .alarm_active);

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   function automatic logic [13:0] pick(sample_set_s s, logic [2:0] c);
      case (c)
         3'h1: return s.supply;
         3'h4: return s.aux;
         3'h5: return s.temp;
         3'h6: return s.full_circle_tilt_output;
         default: return s.half_circle_tilt_output;
      endcase
   endfunction
   function automatic logic hit(logic [2:0] c, logic ab, logic [13:0] t, logic [13:0] v);
      if (c == 3'h0 || c == 3'h2 || c == 3'h3) return 1'b0;
      if (c == 3'h7) return ab ? ($signed(v) > $signed(t)) : ($signed(v) < $signed(t));
      return ab ? (v > t) : (v < t);
   endfunction
   function automatic logic [15:0] mk(int k);
      return (k < 2) ? THRESHOLD_MASK : ((k < 4) ? COUNT_MASK : CONTROL_MASK);
   endfunction

   // a word is two byte frames, low byte at the even address
   task automatic wr(input logic [6:0] a, input logic [15:0] v);
      logic [15:0] x;
      host.xfer({1'b1, a & 7'h7E, v[7:0]}, x);
      host.xfer({1'b1, a | 7'h01, v[15:8]}, x);
   endtask
   // read data only comes back during the following frame
   task automatic rdw(input logic [6:0] a, output logic [15:0] v);
      logic [15:0] x;
      host.xfer({1'b0, a, 8'h00}, x);
      host.xfer(16'h0000, v);
   endtask
   task automatic tick();
      @(negedge sys_clk) sample_tick = 1'b1;
      @(negedge sys_clk) sample_tick = 1'b0;
   endtask
   task automatic finish_test();
      if (err_total == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         finish_test();
      end
   end

   initial begin
      rnd[31:0] = $urandom(32'hFB220C46);
      {reset_n, sample_tick, nv_valid} = 3'h0;
      {misc_claim, misc_level, gpio_drive, gpio_level} = 8'h00;
      nv_image = '0;
      sample_raw = '0;
      sample_filtered = '0;
      repeat (4) @(negedge sys_clk);
      reset_n = 1'b1;
      repeat (4) @(negedge sys_clk);
      for (int k = 0; k < 6; k++) begin
         rdw(7'h20 + 7'(2 * k), rd);
         `CHK("reset value", 16'h0000, rd)
      end
      `CHK("stored image", 80'h0, nv_store)
      // all ones, the unmapped word included, to expose unused bits
      for (int k = 0; k < 6; k++) wr(7'h20 + 7'(2 * k), 16'hFFFF);
      for (int k = 0; k < 6; k++) begin
         rdw(7'h20 + 7'(2 * k), rd);
         `CHK("masked value", (k < 5) ? mk(k) : 16'h0000, rd)
      end
      `CHK("stored image", {THRESHOLD_MASK, THRESHOLD_MASK, COUNT_MASK, COUNT_MASK, CONTROL_MASK}, nv_store)
      for (int i = 0; i < 16; i++) begin
         @(negedge sys_clk);
         rnd = {$urandom, $urandom, $urandom};
         sample_raw = rnd[69:0];
         rnd = {$urandom, $urandom, $urandom};
         sample_filtered = rnd[69:0];
         {misc_claim, misc_level, gpio_drive, gpio_level} = 8'($urandom);
         s1 = i[2:0];
         s2 = 3'($urandom);
         ctl = (16'($urandom) & 16'h0037) | {1'b0, s2, 1'b0, s1, 8'h00};
         t1 = 16'($urandom);
         t2 = 16'($urandom);
         // equal to the limit must not trip either direction
         if (i[3]) t1[13:0] = pick(ctl[4] ? sample_filtered : sample_raw, s1);
         e1 = hit(s1, t1[15], t1[13:0], pick(ctl[4] ? sample_filtered : sample_raw, s1));
         e2 = hit(s2, t2[15], t2[13:0], pick(ctl[5] ? sample_filtered : sample_raw, s2));
         wr(7'h20, t1);
         wr(7'h22, t2);
         wr(7'h28, ctl);
         tick();
         `CHK("alarm one", e1, alarm_active[0])
         `CHK("alarm two", e2, alarm_active[1])
         @(negedge sys_clk);
         for (int j = 0; j < 2; j++) begin
            den = misc_claim[j] | (ctl[2] & (ctl[0] == j[0])) | gpio_drive[j];
            eo = misc_claim[j] ? misc_level[j] : (ctl[2] && ctl[0] == j[0]) ? ~((e1 | e2) ^ ctl[1]) : gpio_level[j];
            `CHK("pin enable", ~den, dio_oe_n[j])
            if (den) `CHK("pin level", eo, dio_out[j])
         end
      end
      // slope: limit 5 per sample over 3 samples, steps of 6 then 4
      for (int a = 0; a < 2; a++) begin
         wr(7'h28, 16'h0000);
         tick();
         wr(7'h24 + 7'(2 * a), 16'h0003);
         wr(7'h20 + 7'(2 * a), 16'h8005);
         wr(7'h28, a ? 16'h9000 : 16'h0900);
         @(negedge sys_clk) sample_raw.supply = 14'h0064;
         tick();
         for (int b = 0; b < 2; b++) begin
            repeat (3) begin
               @(negedge sys_clk) sample_raw.supply = sample_raw.supply + (b ? 14'h0004 : 14'h0006);
               tick();
            end
            `CHK("slope alarm", 1'((b ? 4 : 6) > 5), alarm_active[a])
         end
      end
      // second reset with a stored image present
      @(negedge sys_clk);
      rnd = {$urandom, $urandom, $urandom};
      nv_image = rnd[79:0];
      nv_valid = 1'b1;
      reset_n = 1'b0;
      repeat (4) @(negedge sys_clk);
      reset_n = 1'b1;
      repeat (4) @(negedge sys_clk);
      nv_valid = 1'b0;
      for (int k = 0; k < 5; k++) begin
         rdw(7'h20 + 7'(2 * k), rd);
         `CHK("restored value", nv_image[79 - 16 * k -: 16] & mk(k), rd)
      end
      finish_test();
   end
endmodule // alarm_monitor_test
